/* File: design/modbus_float_write_framer.sv */
// Write request framer with float doubling, Wishbone set-up and local database
// Notes on behaviour
// R1: Float values are 32-bit single precision, carried as two consecutive words.
// R2: With float flag set and R3, R10, R12 met, each value sent is two words, four bytes.
// R3: FC6/FC16 with float flag double bytes only when threshold <= target.
// R4: Doubled mode: point count means float values, count two sends two floats.
// R5: Doubled FC16 frame: node, 0x10, target, count, four bytes per value, data.
// R6: Float flag clear: threshold ignored, one word per point, two bytes each.
// R7: Extended-register slaves treat addresses above 7000 as two-word floats.
// R8: Each value is byte and word reordered by the swap selection.
// R9: Data fetched from the source address, sent to the configured target.
// R10: Float doubling applies only to FC6 and FC16 writes.
// R11: Multi-byte fields and data words go most significant byte first.
// R12: Enable codes 3 and 4 suppress float doubling, plain 16-bit writes.
`timescale 1ns/1ps
module modbus_float_write_framer
  import float_framer_pkg::*;
#(
  parameter int unsigned DB_AW = 8
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [7:0]  tx_data_o,
  output logic             tx_valid_o,
  output logic             tx_last_o,
  input  wire logic        tx_ready_i,
  output logic             busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [15:0]  db_mem [2**DB_AW];
  cmd_s         cmd_reg;
  logic [15:0]  float_start_reg;
  logic         float_flag_reg;
  logic         done_reg;
  logic         rej_reg;
  logic         ack_reg;
  logic [31:0]  rdat_reg;
  frame_state_e state_reg;
  logic [2:0]   hidx_reg;
  logic [16:0]  widx_reg;
  logic [1:0]   bidx_reg;
  logic [1:0]   blast_reg;
  logic         end_reg;
  logic [31:0]  pair_reg;
  logic [7:0]   tx_data_reg;
  logic         tx_valid_reg;
  logic         tx_last_reg;
  logic         busy_reg;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Frame arithmetic
  logic        is_multi;
  logic        is_single;
  logic        fc_ok;
  logic        plain_code;
  logic        float_act;
  logic [16:0] pts;
  logic [16:0] words_total;
  logic [7:0]  byte_cnt;
  logic [2:0]  hdr_len;
  logic [7:0]  hdr_byte;
  logic        adv;

  always_comb begin
    is_multi    = (cmd_reg.func == FC_WRITE_MULTI);
    is_single   = (cmd_reg.func == FC_WRITE_SINGLE);
    // R10 Write codes only
    fc_ok       = is_multi || is_single;
    // R12 Plain-write enable codes
    plain_code  = (cmd_reg.en_code == EN_PLAIN_CONT) || (cmd_reg.en_code == EN_PLAIN_COND);
    // R3 Threshold test; R6 flag clear skips it
    float_act   = float_flag_reg && fc_ok && !plain_code && (float_start_reg <= cmd_reg.target);
    pts         = is_single ? 17'h0_0001 : {1'b0, cmd_reg.count};
    // R2 Two words per value; R4 count counts floats
    words_total = float_act ? {pts[15:0], 1'b0} : pts;
    // R5 Byte count, field is one byte wide
    byte_cnt    = {words_total[6:0], 1'b0};
    hdr_len     = is_multi ? HDR_LEN_MULTI : HDR_LEN_SINGLE;
    adv         = !tx_valid_reg || tx_ready_i;
    // R11 Most significant byte first
    case (hidx_reg)
      3'h0:    hdr_byte = cmd_reg.node;
      3'h1:    hdr_byte = cmd_reg.func;
      3'h2:    hdr_byte = cmd_reg.target[15:8];
      3'h3:    hdr_byte = cmd_reg.target[7:0];
      3'h4:    hdr_byte = cmd_reg.count[15:8];
      3'h5:    hdr_byte = cmd_reg.count[7:0];
      3'h6:    hdr_byte = byte_cnt;
      default: hdr_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data fetch and reorder
  logic [DB_AW-1:0] ra0;
  logic [DB_AW-1:0] ra1;
  logic             lone;
  logic [31:0]      raw_pair;
  logic [31:0]      swapped;

  always_comb begin
    // R9 Source address plus word index
    ra0      = cmd_reg.source[DB_AW-1:0] + widx_reg[DB_AW-1:0];
    ra1      = ra0 + 1'b1;
    lone     = (words_total - widx_reg) == 17'h0_0001;
    // Lone word doubled so the upper half carries its byte order
    raw_pair = lone ? {db_mem[ra0], db_mem[ra0]} : {db_mem[ra0], db_mem[ra1]};
  end

  // R1 R8 Two-word value reorder
  word_swapper u_swap (
    .value_i (raw_pair),
    .code_i  (cmd_reg.swap),
    .value_o (swapped)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  logic        req;
  logic        wr_fire;
  logic        start_req;
  logic [31:0] rd_mux;
  logic        in_db;

  always_comb begin
    req       = wb_cyc_i && wb_stb_i;
    wr_fire   = req && wb_we_i && ack_reg;
    in_db     = wb_adr_i[15:12] == DB_WINDOW_PAGE;
    start_req = wr_fire && (wb_adr_i == OFS_CTRL) && wb_sel_i[0]
                && wb_dat_i[CTRL_START_BIT] && (state_reg == ST_IDLE);
    rd_mux    = 32'h0000_0000;
    if (in_db) begin
      rd_mux = {16'h0000, db_mem[wb_adr_i[DB_AW+1:2]]};
    end else begin
      case (wb_adr_i)
        OFS_CTRL:        rd_mux[CTRL_FLOAT_BIT] = float_flag_reg;
        OFS_FLOAT_START: rd_mux = {16'h0000, float_start_reg};
        OFS_NODE_FUNC:   rd_mux = {10'h000, cmd_reg.swap, 1'b0, cmd_reg.en_code,
                                   cmd_reg.func, cmd_reg.node};
        OFS_TARGET:      rd_mux = {16'h0000, cmd_reg.target};
        OFS_COUNT:       rd_mux = {16'h0000, cmd_reg.count};
        OFS_SOURCE:      rd_mux = {16'h0000, cmd_reg.source};
        OFS_STATUS:      rd_mux = {29'h0000_0000, rej_reg, done_reg, state_reg != ST_IDLE};
        OFS_BYTE_COUNT:  rd_mux = {24'h00_0000, byte_cnt};
        default:         rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= req && !ack_reg;
      if (req && !ack_reg) begin
        rdat_reg <= rd_mux;
      end
    end
  end

  // Set-up frozen during a frame so header and data agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg         <= CMD_RST;
      float_start_reg <= FLOAT_START_RST;
      float_flag_reg  <= 1'b0;
    end else if (wr_fire && (state_reg == ST_IDLE) && !in_db) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            float_flag_reg <= wb_dat_i[CTRL_FLOAT_BIT];
          end
        end
        OFS_FLOAT_START: float_start_reg <= 16'(merge({16'h0000, float_start_reg}, wb_dat_i,
                                                      wb_sel_i));
        OFS_NODE_FUNC: begin
          if (wb_sel_i[0]) cmd_reg.node <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cmd_reg.func <= wb_dat_i[NF_FUNC_LSB +: 8];
          if (wb_sel_i[2]) cmd_reg.en_code <= wb_dat_i[NF_EN_LSB +: 3];
          if (wb_sel_i[2]) cmd_reg.swap <= wb_dat_i[NF_SWAP_LSB +: 2];
        end
        OFS_TARGET: cmd_reg.target <= 16'(merge({16'h0000, cmd_reg.target}, wb_dat_i, wb_sel_i));
        OFS_COUNT:  cmd_reg.count <= 16'(merge({16'h0000, cmd_reg.count}, wb_dat_i, wb_sel_i));
        OFS_SOURCE: cmd_reg.source <= 16'(merge({16'h0000, cmd_reg.source}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_fire && in_db) begin
      db_mem[wb_adr_i[DB_AW+1:2]] <= 16'(merge({16'h0000, db_mem[wb_adr_i[DB_AW+1:2]]},
                                               wb_dat_i, wb_sel_i));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags, set wins over clear
  logic frame_end;
  logic clr_stat;
  assign frame_end = (state_reg == ST_DATA) && adv && (bidx_reg == blast_reg) && end_reg
                     || (state_reg == ST_HEAD) && adv && (hidx_reg == hdr_len - 3'h1)
                        && (words_total == 17'h0_0000);
  assign clr_stat  = wr_fire && (wb_adr_i == OFS_STATUS) && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
      rej_reg  <= 1'b0;
    end else begin
      done_reg <= frame_end || (done_reg && !(clr_stat && wb_dat_i[STAT_DONE_BIT]));
      rej_reg  <= (start_req && (!fc_ok || cmd_reg.en_code == EN_OFF))
                  || (rej_reg && !(clr_stat && wb_dat_i[STAT_REJ_BIT]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      hidx_reg     <= 3'h0;
      widx_reg     <= 17'h0_0000;
      bidx_reg     <= 2'h0;
      blast_reg    <= 2'h0;
      end_reg      <= 1'b0;
      pair_reg     <= 32'h0000_0000;
      tx_data_reg  <= 8'h00;
      tx_valid_reg <= 1'b0;
      tx_last_reg  <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (adv) begin
            tx_valid_reg <= 1'b0;
            tx_last_reg  <= 1'b0;
          end
          if (start_req && fc_ok && cmd_reg.en_code != EN_OFF) begin
            state_reg <= ST_HEAD;
            busy_reg  <= 1'b1;
            hidx_reg  <= 3'h0;
            widx_reg  <= 17'h0_0000;
          end
        end
        ST_HEAD: begin
          if (adv) begin
            tx_data_reg  <= hdr_byte;
            tx_valid_reg <= 1'b1;
            hidx_reg     <= hidx_reg + 3'h1;
            tx_last_reg  <= frame_end;
            if (hidx_reg == hdr_len - 3'h1) begin
              state_reg <= (words_total == 17'h0_0000) ? ST_IDLE : ST_FETCH;
              busy_reg  <= words_total != 17'h0_0000;
            end
          end
        end
        ST_FETCH: begin
          // A taken byte must not be offered twice
          if (adv) begin
            tx_valid_reg <= 1'b0;
          end
          // R8 Reordered value latched
          pair_reg  <= swapped;
          blast_reg <= lone ? 2'h1 : 2'h3;
          end_reg   <= (widx_reg + (lone ? 17'h0_0001 : 17'h0_0002)) >= words_total;
          bidx_reg  <= 2'h0;
          state_reg <= ST_DATA;
        end
        ST_DATA: begin
          if (adv) begin
            // R11 Upper byte leaves first
            tx_data_reg  <= pair_reg[31 - 8*bidx_reg -: 8];
            tx_valid_reg <= 1'b1;
            tx_last_reg  <= frame_end;
            bidx_reg     <= bidx_reg + 2'h1;
            if (bidx_reg == blast_reg) begin
              widx_reg  <= widx_reg + ((blast_reg == 2'h1) ? 17'h0_0001 : 17'h0_0002);
              state_reg <= end_reg ? ST_IDLE : ST_FETCH;
              busy_reg  <= !end_reg;
            end
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  assign wb_ack_o   = ack_reg;
  assign wb_dat_o   = rdat_reg;
  assign tx_data_o  = tx_data_reg;
  assign tx_valid_o = tx_valid_reg;
  assign tx_last_o  = tx_last_reg;
  assign busy_o     = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Fetch address rebuilt from the command, not from the read port
  logic [DB_AW-1:0] chk_src;
  logic [15:0]      chk_word;
  assign chk_src  = DB_AW'(cmd_reg.source + widx_reg[15:0]);
  assign chk_word = db_mem[chk_src];

  sequence s_hdr_byte(logic [2:0] n);
    state_reg == ST_HEAD && adv && hidx_reg == n;
  endsequence

  a_float_bytes: assert property (float_act && is_multi |-> byte_cnt == 8'(cmd_reg.count * 4)) // R5
    else $error("float byte count not four per value");
  a_plain_bytes: assert property (!float_flag_reg && is_multi
                                  |-> byte_cnt == 8'(cmd_reg.count * 2)) // R6
    else $error("plain byte count not two per point");
  a_code_suppress: assert property (plain_code && is_multi
                                    |-> byte_cnt == 8'(cmd_reg.count * 2)) // R12
    else $error("enable code 3/4 still doubled");
  a_threshold_gate: assert property (float_flag_reg && is_multi && !plain_code
                                     && float_start_reg <= cmd_reg.target
                                     |-> byte_cnt == 8'(cmd_reg.count * 4)) // R3
    else $error("no doubling at or above threshold");
  a_float_words: assert property (float_act && is_multi
                                  |-> words_total == {cmd_reg.count, 1'b0}) // R4
    else $error("float word total wrong");
  a_func_byte: assert property (s_hdr_byte(3'h1) |=> tx_data_o == cmd_reg.func) // R5
    else $error("function byte wrong");
  a_addr_msb: assert property (s_hdr_byte(3'h2) |=> tx_data_o == cmd_reg.target[15:8]) // R11
    else $error("target high byte not first");
  a_fetch_source: assert property (state_reg == ST_FETCH && cmd_reg.swap == SWAP_NONE
                                   |=> pair_reg[31:16] == $past(chk_word)) // R9
    else $error("fetch address off source");
  a_swap_words: assert property (cmd_reg.swap == SWAP_WORDS && !lone
                                 |-> swapped == {raw_pair[15:0], raw_pair[31:16]}) // R8
    else $error("word swap wrong");
  a_start_busy: assert property (start_req && fc_ok && cmd_reg.en_code != EN_OFF
                                 |=> state_reg == ST_HEAD ##1 busy_o) // R10
    else $error("frame did not start");

endmodule : modbus_float_write_framer

/* File: common/float_framer_pkg.sv */
// Constants, types and the register map of the float write framer
package float_framer_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Function and enable codes
  localparam logic [7:0]  FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0]  FC_WRITE_MULTI  = 8'h10;
  localparam logic [2:0]  EN_OFF          = 3'h0;
  localparam logic [2:0]  EN_PLAIN_CONT   = 3'h3;
  localparam logic [2:0]  EN_PLAIN_COND   = 3'h4;

  // Swap selections
  localparam logic [1:0]  SWAP_NONE       = 2'h0;
  localparam logic [1:0]  SWAP_WORDS      = 2'h1;
  localparam logic [1:0]  SWAP_BOTH       = 2'h2;
  localparam logic [1:0]  SWAP_BYTES      = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [15:0] OFS_CTRL        = 16'h0000;
  localparam logic [15:0] OFS_FLOAT_START = 16'h0004;
  localparam logic [15:0] OFS_NODE_FUNC   = 16'h0008;
  localparam logic [15:0] OFS_TARGET      = 16'h000C;
  localparam logic [15:0] OFS_COUNT       = 16'h0010;
  localparam logic [15:0] OFS_SOURCE      = 16'h0014;
  localparam logic [15:0] OFS_STATUS      = 16'h0018;
  localparam logic [15:0] OFS_BYTE_COUNT  = 16'h001C;
  localparam logic [3:0]  DB_WINDOW_PAGE  = 4'h1;

  // Field positions
  localparam int unsigned CTRL_START_BIT  = 0;
  localparam int unsigned CTRL_FLOAT_BIT  = 1;
  localparam int unsigned NF_FUNC_LSB     = 8;
  localparam int unsigned NF_EN_LSB       = 16;
  localparam int unsigned NF_SWAP_LSB     = 20;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_DONE_BIT   = 1;
  localparam int unsigned STAT_REJ_BIT    = 2;

  // Header layout
  localparam logic [2:0]  HDR_LEN_MULTI   = 3'h7;
  localparam logic [2:0]  HDR_LEN_SINGLE  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Command set-up
  typedef struct packed {
    logic [7:0]  node;
    logic [7:0]  func;
    logic [2:0]  en_code;
    logic [1:0]  swap;
    logic [15:0] target;
    logic [15:0] count;
    logic [15:0] source;
  } cmd_s;

  localparam cmd_s        CMD_RST         = '0;
  localparam logic [15:0] FLOAT_START_RST = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_HEAD  = 2'b01,
    ST_FETCH = 2'b11,
    ST_DATA  = 2'b10
  } frame_state_e;

endpackage : float_framer_pkg

/* File: design/word_swapper.sv */
// Byte and word reordering of one two-word value
`timescale 1ns/1ps
module word_swapper
  import float_framer_pkg::*;
(
  input  wire logic [31:0] value_i,
  input  wire logic [1:0]  code_i,
  output logic      [31:0] value_o
);

  always_comb begin
    case (code_i)
      SWAP_NONE:  value_o = value_i;
      SWAP_WORDS: value_o = {value_i[15:0], value_i[31:16]};
      SWAP_BOTH:  value_o = {value_i[7:0], value_i[15:8], value_i[23:16], value_i[31:24]};
      SWAP_BYTES: value_o = {value_i[23:16], value_i[31:24], value_i[7:0], value_i[15:8]};
      default:    value_o = value_i;
    endcase
  end

endmodule : word_swapper

/* File: tb/frame_sink.sv */
// Remote slave model: sinks frame bytes with optional back-pressure
`timescale 1ns/1ps
module frame_sink (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  tx_data_i,
  input  wire logic        tx_valid_i,
  input  wire logic        tx_last_i,
  input  wire logic        stall_i,
  output logic             tx_ready_o,
  output logic      [31:0] frames_o
);
  logic [7:0] rx_q[$];
  logic       ext_float;
  int         last_pos;

  ////////////////////////////////////////////////////////////////////////////
  // Slow mode drops ready at random to stretch frames
  always_ff @(posedge clk_i) begin
    if (rst_i) tx_ready_o <= 1'b0;
    else tx_ready_o <= stall_i ? 1'($urandom) : 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // each float arrives as two words, kept as sent
  // extended slaves read targets above 7000 as float values
  always @(posedge clk_i) begin
    if (rst_i) begin
      frames_o <= '0;
      ext_float <= 1'b0;
      last_pos <= 0;
    end else if (tx_valid_i && tx_ready_o) begin
      rx_q.push_back(tx_data_i);
      if (tx_last_i) begin
        frames_o <= frames_o + 32'h0000_0001;
        last_pos <= rx_q.size();
        ext_float <= rx_q.size() > 3 && {rx_q[2], rx_q[3]} > 16'h1B58;
      end
    end
  end
endmodule : frame_sink

/* File: tb/tb_top.sv */
// Self-checking bench of the float write framer
`timescale 1ns/1ps
module tb_top;
  import float_framer_pkg::*;
  localparam int LIMIT = 30000;
  logic        clk_i, rst_i, we, cyc, stb, stall, busy_o, ack, valid, last, ready;
  logic [15:0] adr;
  logic [31:0] wdat, rd, dat_o, frames;
  logic [7:0]  data, exp_bc;
  logic [7:0]  exp_q[$];
  logic [15:0] db_m[256];
  logic [15:0] t;
  int          n_mismatch, check_count, cycles;

  modbus_float_write_framer #(.DB_AW(8)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_we_i(we),
    .wb_sel_i(4'hF), .wb_stb_i(stb), .wb_cyc_i(cyc), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .tx_data_o(data), .tx_valid_o(valid), .tx_last_o(last), .tx_ready_i(ready),
    .busy_o(busy_o));
  frame_sink slave (
    .clk_i(clk_i), .rst_i(rst_i), .tx_data_i(data), .tx_valid_i(valid),
    .tx_last_i(last), .stall_i(stall), .tx_ready_o(ready), .frames_o(frames));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic check(logic [31:0] seen, logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  // Classic cycle: hold until ack is sampled, then one idle cycle
  task automatic wb(logic w, logic [15:0] a, logic [31:0] d);
    adr <= a;
    wdat <= d;
    we <= w;
    cyc <= 1'b1;
    stb <= 1'b1;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  function automatic logic [31:0] swap32(logic [31:0] v, logic [1:0] c);
    case (c)
      SWAP_WORDS: return {v[15:0], v[31:16]};
      SWAP_BOTH:  return {v[7:0], v[15:8], v[23:16], v[31:24]};
      SWAP_BYTES: return {v[23:16], v[31:24], v[7:0], v[15:8]};
      default:    return v;
    endcase
  endfunction : swap32

  function automatic void build(logic fl, logic [15:0] fs, logic [7:0] nd, logic [7:0] fn,
                                logic [2:0] en, logic [1:0] sw, logic [15:0] tg, cn, sr);
    logic        act;
    int          words;
    logic [15:0] w0;
    logic [31:0] v;
    act = fl && en != EN_PLAIN_CONT && en != EN_PLAIN_COND && fs <= tg;
    words = (fn == FC_WRITE_SINGLE) ? 1 : int'(cn);
    if (act) words = words * 2;
    exp_bc = 8'(2 * words);
    exp_q = {nd, fn, tg[15:8], tg[7:0]};
    if (fn == FC_WRITE_MULTI) exp_q = {exp_q, cn[15:8], cn[7:0], exp_bc};
    for (int k = 0; k < words; k += 2) begin
      w0 = db_m[(int'(sr) + k) % 256];
      v = swap32({w0, db_m[(int'(sr) + k + 1) % 256]}, sw);
      if (k + 1 < words) exp_q = {exp_q, v[31:24], v[23:16], v[15:8], v[7:0]};
      else if (sw[1]) exp_q = {exp_q, w0[7:0], w0[15:8]};
      else exp_q = {exp_q, w0[15:8], w0[7:0]};
    end
  endfunction : build

  task automatic setup(logic fl, logic [15:0] fs, logic [7:0] nd, logic [7:0] fn,
                       logic [2:0] en, logic [1:0] sw, logic [15:0] tg, cn, sr);
    wb(1, OFS_CTRL, {30'h0, fl, 1'b0});
    wb(1, OFS_FLOAT_START, {16'h0, fs});
    wb(1, OFS_NODE_FUNC, {10'h0, sw, 1'b0, en, fn, nd});
    wb(1, OFS_TARGET, {16'h0, tg});
    wb(1, OFS_COUNT, {16'h0, cn});
    wb(1, OFS_SOURCE, {16'h0, sr});
    slave.rx_q.delete();
    wb(1, OFS_CTRL, {30'h0, fl, 1'b1});
  endtask : setup

  task automatic run(logic fl, logic [15:0] fs, logic [7:0] nd, logic [7:0] fn,
                     logic [2:0] en, logic [1:0] sw, logic [15:0] tg, cn, sr);
    logic [31:0] f0;
    int          n;
    build(fl, fs, nd, fn, en, sw, tg, cn, sr);
    f0 = frames;
    setup(fl, fs, nd, fn, en, sw, tg, cn, sr);
    // Set-up writes are refused while a frame is being built
    wb(1, OFS_TARGET, {16'h0, ~tg});
    check(32'(busy_o), 32'h1);
    n = 0;
    while ((frames === f0 || busy_o !== 1'b0) && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    check(frames - f0, 32'h1);
    check(32'(slave.last_pos), 32'(exp_q.size()));
    check(32'(slave.ext_float), 32'(tg > 16'h1B58));
    check(32'(slave.rx_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) if (i < slave.rx_q.size()) check(slave.rx_q[i], exp_q[i]);
    wb(0, OFS_BYTE_COUNT, '0);
    check(rd, {24'h0, exp_bc});
    wb(0, OFS_TARGET, '0);
    check(rd, {16'h0, tg});
    wb(0, OFS_STATUS, '0);
    check(rd, 32'h2);
    wb(1, OFS_STATUS, 32'h7);
    $display("frame fn=%h en=%0d bytes=%0d done", fn, en, exp_q.size());
  endtask : run

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    {rst_i, we, cyc, stb, stall, adr, wdat} = {5'h10, 48'h0};
    void'($urandom(32'h354891a6));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1, 16'h0800, 32'hFFFF_FFFF);
    for (int a = 0; a <= 32'h20; a += 4) begin
      wb(0, (a == 32'h20) ? 16'h0800 : 16'(a), '0);
      check(rd, '0);
    end
    $display("reset values done");
    for (int i = 0; i < 256; i++) begin
      db_m[i] = 16'($urandom);
      wb(1, 16'h1000 + 16'(4 * i), {16'h0, db_m[i]});
    end
    run(1, 16'h1BBC, 8'h01, FC_WRITE_MULTI, 3'h1, SWAP_NONE, 16'h1BBC, 16'h2, 16'h05DC);
    run(1, 16'h1BBD, 8'h01, FC_WRITE_MULTI, 3'h1, SWAP_NONE, 16'h1BBC, 16'h2, 16'h05DC);
    run(0, 16'h0000, 8'h01, FC_WRITE_MULTI, 3'h1, SWAP_NONE, 16'h1BBC, 16'h2, 16'h05DC);
    run(1, 16'h0000, 8'h07, FC_WRITE_SINGLE, 3'h2, SWAP_BOTH, 16'h0040, 16'h5, 16'h00FF);
    run(0, 16'h0000, 8'h07, FC_WRITE_SINGLE, 3'h1, SWAP_BYTES, 16'h0040, 16'h5, 16'h0010);
    run(0, 16'h0000, 8'h09, FC_WRITE_MULTI, 3'h1, SWAP_BOTH, 16'h0100, 16'h3, 16'h00FE);
    run(1, 16'h0000, 8'h09, FC_WRITE_MULTI, 3'h1, SWAP_NONE, 16'h0100, 16'h0, 16'h0000);
    for (int s = 0; s < 4; s++)
      run(1, 16'h0000, 8'h11, FC_WRITE_MULTI, 3'h1, 2'(s), 16'h1B58, 16'h1, 16'h00FE);
    for (int e = 1; e < 5; e++)
      run(1, 16'h0010, 8'h22, FC_WRITE_MULTI, 3'(e), SWAP_WORDS, 16'h0010, 16'h2, 16'h0028);
    // Bad function or disabled command must not frame
    for (int j = 0; j < 2; j++) begin
      t = frames[15:0];
      setup(1, 16'h0, 8'h01, j ? FC_WRITE_MULTI : 8'h03, 3'(j ? 0 : 1), SWAP_NONE,
            16'h0, 16'h1, 16'h0);
      repeat (6) @(posedge clk_i);
      wb(0, OFS_STATUS, '0);
      check(rd, 32'h4);
      check({16'h0, frames[15:0]}, {16'h0, t});
      wb(1, OFS_STATUS, 32'h7);
    end
    $display("reject done");
    repeat (16) begin
      stall <= 1'($urandom);
      t = 16'($urandom);
      run(1'($urandom), t + 16'($urandom_range(0, 2)) - 16'h1, 8'($urandom),
          $urandom_range(0, 1) ? FC_WRITE_MULTI : FC_WRITE_SINGLE, 3'($urandom_range(1, 4)),
          2'($urandom), t, 16'($urandom_range(0, 6)), 16'($urandom));
    end
    end_sim();
  end
endmodule : tb_top
